// file: sim/gated_counter_monitor.sv
// Purpose: Concurrent checks on the ports of the gated counter.
// Assumes: One clock; register contents are shadowed from port writes.
// Notes:   Bound to the counter at the foot of this file.

`timescale 1ns/100ps

module gated_counter_monitor (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // Register port
  input wire logic [7:0] address,
  input wire logic [7:0] write_data,
  input wire logic       write_strobe,
  input wire logic       read_strobe,
  input wire logic [7:0] read_data,
  // Pins and system state
  input wire logic       external_count_input,
  input wire logic       lp_osc_clock,
  input wire logic       gate_input_n,
  input wire logic       internal_osc_no_clkout,
  input wire logic       sleep_active,
  // Status outputs
  input wire logic       irq_request,
  input wire logic       wake_request,
  input wire logic       lp_osc_on
);
  // ********
  // Shadows
  // ********
  logic [6:0] ctrl_q;
  logic [6:0] next_ctrl_q;
  logic [2:0] en_q;
  logic [2:0] next_en_q;

  // Track control and the three enables {global, peripheral, rollover}.
  always_comb begin
    next_ctrl_q = ctrl_q;
    next_en_q = en_q;
    if (write_strobe && address == gated_counter_pkg::ADDR_CONTROL) begin
      next_ctrl_q = write_data[6:0];
    end
    if (write_strobe && address == gated_counter_pkg::ADDR_IRQ_CONTROL) begin
      next_en_q[2:1] = write_data[7:6];
    end
    if (write_strobe && address == gated_counter_pkg::ADDR_ENABLE) begin
      next_en_q[0] = write_data[0];
    end
  end

  // Shadow registers.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q <= 7'h00;
      en_q <= 3'h0;
    end else begin
      ctrl_q <= next_ctrl_q;
      en_q <= next_en_q;
    end
  end

  // ********
  // Checks
  // ********
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_ctrl_read;
    read_strobe && address == gated_counter_pkg::ADDR_CONTROL;
  endsequence

  sequence s_quiet_irq;
    !write_strobe ##1 !write_strobe && irq_request;
  endsequence

  a_read_idle_zero: assert property (!read_strobe |=> read_data == 8'h00)
    else $error("read data not zero outside a read");
  a_ctrl_top_zero:
    assert property (s_ctrl_read |=> read_data == {1'b0, ctrl_q})
    else $error("control readback wrong");
  a_flag_bits_only:
    assert property (read_strobe && address == gated_counter_pkg::ADDR_FLAG
                     |=> read_data[7:1] == 7'h00)
    else $error("flag register upper bits set");
  a_unmapped_zero:
    assert property (read_strobe && address == 8'h20 |=> read_data == 8'h00)
    else $error("unmapped read not zero");
  a_irq_all_enables:
    assert property (irq_request |-> $past(en_q) == 3'h7)
    else $error("interrupt request without all enables");
  a_wake_needs_sleep:
    assert property (wake_request |-> $past(sleep_active) && $past(en_q[1:0]) == 2'h3)
    else $error("wake request without sleep or enables");
  a_lp_osc_follow:
    assert property (lp_osc_on == $past(ctrl_q[3] && internal_osc_no_clkout))
    else $error("low-power oscillator enable wrong");
  a_irq_stays_set:
    assert property (s_quiet_irq |=> irq_request)
    else $error("interrupt request dropped without a write");
endmodule

bind gated_counter gated_counter_monitor i_gated_counter_monitor (
  .clock(clock), .rst(rst), .address(address), .write_data(write_data),
  .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
  .external_count_input(external_count_input), .lp_osc_clock(lp_osc_clock),
  .gate_input_n(gate_input_n), .internal_osc_no_clkout(internal_osc_no_clkout),
  .sleep_active(sleep_active), .irq_request(irq_request),
  .wake_request(wake_request), .lp_osc_on(lp_osc_on)
);

// file: sim/gated_counter_tb_top.sv
// Purpose: Self-checking bench for the gated counter over its register port.
// Assumes: Count windows are measured in clock cycles between two control writes.
// Notes:   Each table row presets the count, runs one mode, stops, and reads back.

`timescale 1ns/100ps

module gated_counter_tb_top;
  // Flags are {gate_n, sleep, internal_oscillator, use_lp}; win is the run window or pulse half period.
  typedef struct {
    logic [7:0]  ctrl;
    logic [3:0]  flags;
    int          pulses;
    int          win;
    logic [15:0] preset;
    logic [15:0] want;
  } case_t;

  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] address = 8'h00;
  logic [7:0] write_data = 8'h00;
  logic       write_strobe = 1'b0;
  logic       read_strobe = 1'b0;
  logic [7:0] read_data;
  logic       ext_pin;
  logic       lp_pin;
  logic       gate_input_n = 1'b1;
  logic       internal_osc_no_clkout = 1'b0;
  logic       sleep_active = 1'b0;
  logic       irq_request;
  logic       wake_request;
  logic       lp_osc_on;
  logic       start = 1'b0;
  logic       use_lp = 1'b0;
  logic [7:0] pulses = 8'h00;
  logic [7:0] half = 8'h01;
  logic       busy;
  int         err_total = 0;
  int         checks = 0;
  int         cycles = 0;
  case_t      cases [14] = '{
    '{8'h01, 4'h8, 0, 16, 16'h0000, 16'h0010},
    '{8'h11, 4'h8, 0, 33, 16'h0000, 16'h0010},
    '{8'h21, 4'h8, 0, 66, 16'h0000, 16'h0010},
    '{8'h31, 4'h8, 0, 132, 16'h0000, 16'h0010},
    '{8'h31, 4'h8, 0, 132, 16'h0000, 16'h0010},
    '{8'h41, 4'h8, 0, 16, 16'h0000, 16'h0000},
    '{8'h41, 4'h0, 0, 16, 16'h0000, 16'h0010},
    '{8'h00, 4'h8, 0, 16, 16'h1234, 16'h1234},
    '{8'h05, 4'hc, 0, 16, 16'h0000, 16'h0000},
    '{8'h03, 4'h8, 5, 2, 16'h0000, 16'h0004},
    '{8'h07, 4'hc, 5, 5, 16'h0000, 16'h0004},
    '{8'h0b, 4'hb, 5, 2, 16'h0000, 16'h0004},
    '{8'h0b, 4'h9, 5, 2, 16'h0000, 16'h0000},
    '{8'h01, 4'h8, 0, 2, 16'hfffe, 16'h0000}
  };

  gated_counter i_gated_counter (
    .clock(clock), .rst(rst), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
    .external_count_input(ext_pin), .lp_osc_clock(lp_pin), .gate_input_n(gate_input_n),
    .internal_osc_no_clkout(internal_osc_no_clkout), .sleep_active(sleep_active),
    .irq_request(irq_request), .wake_request(wake_request), .lp_osc_on(lp_osc_on)
  );

  pulse_source i_pulse_source (
    .clock(clock), .start(start), .use_lp(use_lp), .pulses(pulses), .half(half),
    .ext_pin(ext_pin), .lp_pin(lp_pin), .busy(busy)
  );

  // ********
  // Clock and watchdog
  // ********
  always #20 clock = ~clock;

  // A hung wait would otherwise stall the run, so cap it well above the expected length.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      print_verdict();
    end
  end

  // ********
  // Tasks
  // ********
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
    @(posedge clock);
  endtask

  // Read data stand only in the cycle after the strobe, so sample mid-cycle.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    @(negedge clock);
    d = read_data;
    @(posedge clock);
  endtask

  task automatic chk(input string what, input logic [15:0] want, input logic [15:0] got);
    checks++;
    if (got !== want) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, want, got);
    end
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] want);
    logic [7:0] d;
    rd(a, d);
    chk(what, {8'h00, want}, {8'h00, d});
  endtask

  task automatic settle();
    repeat (3) @(posedge clock);
  endtask

  // Preset, run one mode, stop, then read both count bytes.
  task automatic run_case(input case_t c);
    logic [7:0] lo;
    logic [7:0] hi;
    int         n;
    {gate_input_n, sleep_active, internal_osc_no_clkout, use_lp} <= c.flags;
    pulses <= c.pulses[7:0];
    half <= c.win[7:0];
    wr(gated_counter_pkg::ADDR_COUNT_LOW, c.preset[7:0]);
    wr(gated_counter_pkg::ADDR_COUNT_HIGH, c.preset[15:8]);
    wr(gated_counter_pkg::ADDR_CONTROL, c.ctrl);
    if (c.pulses > 0) begin
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      n = 0;
      @(negedge clock);
      while (busy === 1'b1 && n < 400) begin
        @(negedge clock);
        n++;
      end
      chk("burst end", 16'h0000, {15'h0000, busy});
      repeat (8) @(posedge clock);
    end else begin
      repeat (c.win - 2) @(posedge clock);
    end
    wr(gated_counter_pkg::ADDR_CONTROL, 8'h00);
    repeat (4) @(posedge clock);
    rd(gated_counter_pkg::ADDR_COUNT_LOW, lo);
    rd(gated_counter_pkg::ADDR_COUNT_HIGH, hi);
    chk("count", c.want, {hi, lo});
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ********
  // Main sequence
  // ********
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rchk("control reset", gated_counter_pkg::ADDR_CONTROL, 8'h00);
    rchk("count reset", gated_counter_pkg::ADDR_COUNT_HIGH, 8'h00);
    wr(gated_counter_pkg::ADDR_CONTROL, 8'hfe);
    rchk("control top bit", gated_counter_pkg::ADDR_CONTROL, 8'h7e);
    rchk("unmapped", 8'h20, 8'h00);
    // The counter is stopped and the flag cleared before the enables go on.
    wr(gated_counter_pkg::ADDR_CONTROL, 8'h00);
    wr(gated_counter_pkg::ADDR_FLAG, 8'h00);
    wr(gated_counter_pkg::ADDR_ENABLE, 8'h01);
    wr(gated_counter_pkg::ADDR_IRQ_CONTROL, 8'hc0);
    foreach (cases[i]) begin
      run_case(cases[i]);
    end
    // The last row wrapped the count, so the flag and the request are up.
    rchk("flag", gated_counter_pkg::ADDR_FLAG, 8'h01);
    chk("irq", 16'h0001, {15'h0000, irq_request});
    wr(gated_counter_pkg::ADDR_IRQ_CONTROL, 8'h40);
    settle();
    chk("irq masked", 16'h0000, {15'h0000, irq_request});
    sleep_active <= 1'b1;
    settle();
    chk("wake", 16'h0001, {15'h0000, wake_request});
    wr(gated_counter_pkg::ADDR_IRQ_CONTROL, 8'hc0);
    settle();
    chk("irq held", 16'h0001, {15'h0000, irq_request});
    wr(gated_counter_pkg::ADDR_FLAG, 8'h00);
    settle();
    chk("irq cleared", 16'h0000, {15'h0000, irq_request});
    rchk("flag cleared", gated_counter_pkg::ADDR_FLAG, 8'h00);
    print_verdict();
  end
endmodule

// file: sim/pulse_source.sv
// Purpose: Far-side model driving bursts on the count pin or the low-power clock pin.
// Assumes: Bench asks for one burst at a time with start.
// Notes:   Both pins rest low between bursts, as a stopped external source would.

`timescale 1ns/100ps

module pulse_source (
  // Clock
  input  wire logic       clock,
  // Request from the bench
  input  wire logic       start,
  input  wire logic       use_lp,
  input  wire logic [7:0] pulses,
  input  wire logic [7:0] half,
  // Pins and status
  output logic            ext_pin,
  output logic            lp_pin,
  output logic            busy
);
  // Idle pins at time zero.
  initial begin
    ext_pin = 1'b0;
    lp_pin = 1'b0;
    busy = 1'b0;
  end

  // Each pulse is a high phase then a low phase, so every later rise follows a fall.
  always @(posedge clock) begin
    if (start && !busy) begin
      busy <= 1'b1;
      for (int i = 0; i < pulses; i++) begin
        if (use_lp) begin
          lp_pin <= 1'b1;
        end else begin
          ext_pin <= 1'b1;
        end
        repeat (half) @(posedge clock);
        lp_pin <= 1'b0;
        ext_pin <= 1'b0;
        repeat (half) @(posedge clock);
      end
      busy <= 1'b0;
    end
  end
endmodule

// file: verilog/count_divider.sv
// Purpose: Input divider of 1, 2, 4 or 8 for the count clock.
// Assumes: tick is a one-cycle pulse per source event.
// Notes:   The carry is registered, so it trails its tick by one cycle.

`timescale 1ns/100ps

module count_divider (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Control
  input  wire logic       clear,
  input  wire logic       tick,
  input  wire logic [1:0] select,
  // Result
  output logic            carry
);

  logic [2:0] count;
  logic [2:0] next_count;
  logic       next_carry;

  // Terminal count of the divider for a select code.
  function automatic logic [2:0] div_limit(input logic [1:0] code);
    case (code)
      2'h0:    div_limit = gated_counter_pkg::DIV_LIMIT_1;
      2'h1:    div_limit = gated_counter_pkg::DIV_LIMIT_2;
      2'h2:    div_limit = gated_counter_pkg::DIV_LIMIT_4;
      default: div_limit = gated_counter_pkg::DIV_LIMIT_8;
    endcase
  endfunction

  // Count ticks up to the limit; a clear forgets any partial count.
  always_comb begin
    next_count = count;
    next_carry = 1'b0;
    if (clear) begin
      next_count = gated_counter_pkg::DIV_ZERO;
    end else if (tick) begin
      if (count >= div_limit(select)) begin
        next_count = gated_counter_pkg::DIV_ZERO;
        next_carry = 1'b1;
      end else begin
        next_count = count + gated_counter_pkg::DIV_STEP;
      end
    end
  end

  // Divider registers.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count <= gated_counter_pkg::DIV_ZERO;
      carry <= 1'b0;
    end else begin
      count <= next_count;
      carry <= next_carry;
    end
  end

endmodule

// file: verilog/count_edge_unit.sv
// Purpose: Rising-edge detector for the external count input.
// Assumes: The raw input is sampled on the system clock.
// Notes:   The rise pulse is registered and lasts one cycle.

`timescale 1ns/100ps

module count_edge_unit (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Control
  input  wire logic raw,
  input  wire logic bypass_sync,
  input  wire logic arm_clear,
  // Result
  output logic      rise
);

  logic                       sync_first;
  logic                       sync_second;
  logic                       prev;
  logic                       next_prev;
  logic                       selected;
  logic                       next_rise;
  gated_counter_pkg::edge_arm_t arm;
  gated_counter_pkg::edge_arm_t next_arm;

  // Two-stage synchroniser; the first stage feeds only the second.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_first  <= 1'b0;
      sync_second <= 1'b0;
    end else begin
      sync_first  <= raw;
      sync_second <= sync_first;
    end
  end

  // Choose the synchronised or the direct path, then look for edges.
  always_comb begin
    selected  = bypass_sync ? raw : sync_second;
    next_prev = selected;
    next_arm  = arm;
    next_rise = 1'b0;
    case (arm)
      gated_counter_pkg::WAIT_FALL: begin
        if (prev && !selected) begin
          next_arm = gated_counter_pkg::ARMED;
        end
      end
      gated_counter_pkg::ARMED: begin
        next_rise = selected && !prev;
      end
      default: begin
        next_arm = gated_counter_pkg::WAIT_FALL;
      end
    endcase
    if (arm_clear) begin
      next_arm  = gated_counter_pkg::WAIT_FALL;
      next_rise = 1'b0;
    end
  end

  // Edge state registers.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prev <= 1'b0;
      arm  <= gated_counter_pkg::WAIT_FALL;
      rise <= 1'b0;
    end else begin
      prev <= next_prev;
      arm  <= next_arm;
      rise <= next_rise;
    end
  end

endmodule

// file: verilog/gated_counter.sv
// Purpose: 16-bit gated timer and counter with divider, rollover flag and wake.
// Assumes: clock is the instruction clock; count pins pass a two-stage synchroniser unless it is bypassed.
// Notes:   Register port is byte wide; read data appear only in the cycle after a read.
//
// Behaviour
// - Sixteen-bit counter with timer, synchronised counter and unsynchronised counter modes.
// - Timer mode advances once per instruction cycle through divider, run and gate.
// - Counter mode advances on rising external edges only, never falling ones.
// - A rising edge counts only after a falling edge was first seen.
// - Gate enable ignored when stopped; when set, count only while gate low.
// - Wrapping from all ones to zero sets the rollover flag.
// - Interrupt request needs rollover enable, peripheral enable and global enable.
// - Rollover flag stays set until software clears it.
// - Two-bit select divides the count clock by one, two, four or eight.
// - Divider is hidden and cleared by any write to a count byte.
// - Low-power oscillator enable works only with internal oscillator, no clock out.
// - Sync bypass bit acts only when the external source is selected.
// - Source select picks external rising edges or the instruction clock.
// - Run enable starts the counter; clearing it holds the value.
// - Top bit of the control register reads as zero.
// - Unsynchronised mode keeps counting in sleep; rollover can wake the processor.
//
// The address-and-strobe port was chosen for this implementation.

`timescale 1ns/100ps

module gated_counter (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Register port
  input  wire logic [7:0] address,
  input  wire logic [7:0] write_data,
  input  wire logic       write_strobe,
  input  wire logic       read_strobe,
  output logic      [7:0] read_data,
  // Pins
  input  wire logic       external_count_input,
  input  wire logic       lp_osc_clock,
  input  wire logic       gate_input_n,
  // System state
  input  wire logic       internal_osc_no_clkout,
  input  wire logic       sleep_active,
  // Status outputs
  output logic            irq_request,
  output logic            wake_request,
  output logic            lp_osc_on
);

  // ****************************************
  // Address decode
  // ****************************************

  // A strobe hits a register when its address matches.
  function automatic logic hit(input logic       strobe,
                               input logic [7:0] addr,
                               input logic [7:0] target);
    hit = strobe && (addr == target);
  endfunction

  logic wr_irq_control;
  logic wr_flag;
  logic wr_low;
  logic wr_high;
  logic wr_control;
  logic wr_enable;

  // Write decode for every register.
  always_comb begin
    wr_irq_control = hit(write_strobe, address, gated_counter_pkg::ADDR_IRQ_CONTROL);
    wr_flag        = hit(write_strobe, address, gated_counter_pkg::ADDR_FLAG);
    wr_low         = hit(write_strobe, address, gated_counter_pkg::ADDR_COUNT_LOW);
    wr_high        = hit(write_strobe, address, gated_counter_pkg::ADDR_COUNT_HIGH);
    wr_control     = hit(write_strobe, address, gated_counter_pkg::ADDR_CONTROL);
    wr_enable      = hit(write_strobe, address, gated_counter_pkg::ADDR_ENABLE);
  end

  // ****************************************
  // Software registers
  // ****************************************

  gated_counter_pkg::counter_control_t control;
  gated_counter_pkg::counter_control_t next_control;
  logic                                global_irq_enable;
  logic                                next_global_irq_enable;
  logic                                peripheral_irq_enable;
  logic                                next_peripheral_irq_enable;
  logic                                rollover_irq_enable;
  logic                                next_rollover_irq_enable;

  // Control and enable bits take plain writes.
  always_comb begin
    next_control               = control;
    next_global_irq_enable     = global_irq_enable;
    next_peripheral_irq_enable = peripheral_irq_enable;
    next_rollover_irq_enable   = rollover_irq_enable;
    if (wr_control) begin
      next_control        = write_data;
      next_control.unused = 1'b0;
    end
    if (wr_irq_control) begin
      next_global_irq_enable     = write_data[gated_counter_pkg::GLOBAL_IRQ_BIT];
      next_peripheral_irq_enable = write_data[gated_counter_pkg::PERIPH_IRQ_BIT];
    end
    if (wr_enable) begin
      next_rollover_irq_enable = write_data[gated_counter_pkg::ROLLOVER_IE_BIT];
    end
  end

  // Software register flops.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      control               <= gated_counter_pkg::CONTROL_RESET;
      global_irq_enable     <= 1'b0;
      peripheral_irq_enable <= 1'b0;
      rollover_irq_enable   <= 1'b0;
    end else begin
      control               <= next_control;
      global_irq_enable     <= next_global_irq_enable;
      peripheral_irq_enable <= next_peripheral_irq_enable;
      rollover_irq_enable   <= next_rollover_irq_enable;
    end
  end

  // ****************************************
  // Count source selection
  // ****************************************

  logic lp_select;
  logic source_raw;
  logic external_mode;
  logic unsync_mode;
  logic gate_open;
  logic counting;
  logic source_tick;
  logic edge_rise;

  // The oscillator enable only matters with the internal oscillator and
  // no clock output; otherwise the pin is shared and the bit is ignored.
  always_comb begin
    lp_select     = control.low_power_osc_enable && internal_osc_no_clkout;
    source_raw    = lp_select ? lp_osc_clock : external_count_input;
    external_mode = control.clock_source_select;
    unsync_mode   = external_mode && control.sync_bypass_bit;
    gate_open     = !control.gate_enable_bit || !gate_input_n;
    // Sleep freezes every mode except the unsynchronised counter.
    counting      = control.run_enable_bit && gate_open
                    && (!sleep_active || unsync_mode);
    source_tick   = external_mode ? edge_rise : 1'b1;
  end

  // Edge detector; it re-arms whenever the counter stops or leaves counter
  // mode, so a level already high at start does not count.
  count_edge_unit edge_unit (
    .clock       (clock),
    .rst         (rst),
    .raw         (source_raw),
    .bypass_sync (unsync_mode),
    .arm_clear   (!control.run_enable_bit || !external_mode),
    .rise        (edge_rise)
  );

  logic divider_carry;

  // Any write to either count byte discards a partial division.
  count_divider divider (
    .clock  (clock),
    .rst    (rst),
    .clear  (wr_low || wr_high),
    .tick   (counting && source_tick),
    .select (control.input_divide_select),
    .carry  (divider_carry)
  );

  // ****************************************
  // Sixteen-bit count and rollover flag
  // ****************************************

  logic [15:0] count;
  logic [15:0] next_count;
  logic        rollover;
  logic        rollover_flag;
  logic        next_rollover_flag;

  // Increment on divider carry; a byte write wins over the increment of
  // that byte, since writing a running counter is unpredictable anyway.
  always_comb begin
    next_count = count;
    rollover   = 1'b0;
    if (divider_carry) begin
      next_count = count + gated_counter_pkg::COUNT_STEP;
      rollover   = (count == gated_counter_pkg::COUNT_MAX);
    end
    if (wr_low) begin
      next_count[7:0] = write_data;
    end
    if (wr_high) begin
      next_count[15:8] = write_data;
    end
  end

  // The flag is sticky; a rollover in the clearing cycle still sets it.
  always_comb begin
    next_rollover_flag = rollover_flag;
    if (wr_flag) begin
      next_rollover_flag = write_data[gated_counter_pkg::ROLLOVER_BIT];
    end
    if (rollover) begin
      next_rollover_flag = 1'b1;
    end
  end

  // Count and flag registers.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count         <= gated_counter_pkg::COUNT_RESET;
      rollover_flag <= 1'b0;
    end else begin
      count         <= next_count;
      rollover_flag <= next_rollover_flag;
    end
  end

  // ****************************************
  // Request outputs
  // ****************************************

  logic next_irq_request;
  logic next_wake_request;

  // Wake needs no global enable; the interrupt needs all three enables.
  // Software is expected to clear count and flag before enabling.
  always_comb begin
    next_irq_request  = rollover_flag && rollover_irq_enable
                        && peripheral_irq_enable && global_irq_enable;
    next_wake_request = rollover_flag && rollover_irq_enable
                        && peripheral_irq_enable && sleep_active;
  end

  // Request flops.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_request  <= 1'b0;
      wake_request <= 1'b0;
      lp_osc_on    <= 1'b0;
    end else begin
      irq_request  <= next_irq_request;
      wake_request <= next_wake_request;
      lp_osc_on    <= lp_select;
    end
  end

  // ****************************************
  // Read path
  // ****************************************

  logic [7:0] next_read_data;

  // Data stand only in the cycle after a read; unmapped addresses read zero.
  always_comb begin
    next_read_data = gated_counter_pkg::BYTE_ZERO;
    if (read_strobe) begin
      case (address)
        gated_counter_pkg::ADDR_IRQ_CONTROL: begin
          next_read_data[gated_counter_pkg::GLOBAL_IRQ_BIT] = global_irq_enable;
          next_read_data[gated_counter_pkg::PERIPH_IRQ_BIT] = peripheral_irq_enable;
        end
        gated_counter_pkg::ADDR_FLAG: begin
          next_read_data[gated_counter_pkg::ROLLOVER_BIT] = rollover_flag;
        end
        gated_counter_pkg::ADDR_COUNT_LOW: begin
          next_read_data = count[7:0];
        end
        gated_counter_pkg::ADDR_COUNT_HIGH: begin
          next_read_data = count[15:8];
        end
        gated_counter_pkg::ADDR_CONTROL: begin
          next_read_data = control;
        end
        gated_counter_pkg::ADDR_ENABLE: begin
          next_read_data[gated_counter_pkg::ROLLOVER_IE_BIT] = rollover_irq_enable;
        end
        default: begin
          next_read_data = gated_counter_pkg::BYTE_ZERO;
        end
      endcase
    end
  end

  // Read data register.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      read_data <= gated_counter_pkg::BYTE_ZERO;
    end else begin
      read_data <= next_read_data;
    end
  end

endmodule

// file: verilog/gated_counter_pkg.sv
// Purpose: Shared constants, field layout and types for the gated 16-bit counter.
// Assumes: Byte-wide register port, one system clock at the instruction rate.
// Notes:   Every offset, bit position, multi-bit reset value and divider limit lives here.

package gated_counter_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_IRQ_CONTROL   = 8'h0b;
  localparam logic [7:0] ADDR_FLAG          = 8'h0c;
  localparam logic [7:0] ADDR_COUNT_LOW     = 8'h0e;
  localparam logic [7:0] ADDR_COUNT_HIGH    = 8'h0f;
  localparam logic [7:0] ADDR_CONTROL       = 8'h10;
  localparam logic [7:0] ADDR_ENABLE        = 8'h8c;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned GLOBAL_IRQ_BIT    = 7;
  localparam int unsigned PERIPH_IRQ_BIT    = 6;
  localparam int unsigned ROLLOVER_BIT      = 0;
  localparam int unsigned ROLLOVER_IE_BIT   = 0;

  // ****************************************
  // Reset values and limits
  // ****************************************
  localparam logic [7:0]  BYTE_ZERO         = 8'h00;
  localparam logic [15:0] COUNT_RESET       = 16'h0000;
  localparam logic [15:0] COUNT_MAX         = 16'hffff;
  localparam logic [15:0] COUNT_STEP        = 16'h0001;

  // Divider terminal counts for 1:1, 1:2, 1:4 and 1:8.
  localparam logic [2:0]  DIV_LIMIT_1       = 3'h0;
  localparam logic [2:0]  DIV_LIMIT_2       = 3'h1;
  localparam logic [2:0]  DIV_LIMIT_4       = 3'h3;
  localparam logic [2:0]  DIV_LIMIT_8       = 3'h7;
  localparam logic [2:0]  DIV_ZERO          = 3'h0;
  localparam logic [2:0]  DIV_STEP          = 3'h1;

  // ****************************************
  // Types
  // ****************************************
  // Control register layout, bit 7 first.
  typedef struct packed {
    logic       unused;
    logic       gate_enable_bit;
    logic [1:0] input_divide_select;
    logic       low_power_osc_enable;
    logic       sync_bypass_bit;
    logic       clock_source_select;
    logic       run_enable_bit;
  } counter_control_t;

  localparam counter_control_t CONTROL_RESET = '0;

  // Arming state of the external edge detector.
  typedef enum logic {
    WAIT_FALL,
    ARMED
  } edge_arm_t;

endpackage
